//--- fspa_top.sv
`timescale 1ns/1ns
`include "fspa_consts.svh"

// Summary of operation
// R1 - Frame edge marks next clock rising edge
// R2 - Rising or falling frame edge selectable
// R3 - Source keeps pulse rate integer below clock
// R4 - Any input or output may carry frame
// R5 - Frame rates EPPS up to 8kHz accepted
// R6 - Source holds each pulse ten nanoseconds
// R7 - Frame clock at most 150MHz, integer related
// R8 - Output rates independent, integer for alignment; here all outputs share one clock divider and one frame divider
// R9 - Outputs align to first clock after pulse
// R10 - Several output pulse widths selectable
// R11 - Enabled frame sync realigns the outputs
// R12 - Rising edge default, falling when selected
// R13 - Sync mode uses pulse edge itself
// R14 - Any input or output may carry sync
// R15 - Sync rates EPPS up to 8kHz accepted
// R16 - Sync clock at most 1GHz, integer multiple
// R17 - Software keeps sync outputs integer related
// R18 - Sync outputs align to first sync edge
// R19 - Falling sync edge when edge bit set
// R20 - Synchronise, detect edge, one-cycle strobe
module fspa_top #(
  parameter int NUM_IN = 4,
  parameter int NUM_OUT = 8,
  parameter int SELW = 2
) (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Link side, clocked by the associated input clock.
  input wire logic associated_input_clock,
  input wire logic [NUM_IN-1:0] pulse_input,
  output logic [NUM_OUT-1:0] aligned_output_clock,
  output logic pulse_output,
  // Configuration, core domain.
  input wire fspa_pkg::fspa_mode_t align_mode,
  input wire logic edge_fall,
  input wire logic frame_align_enable,
  input wire logic [SELW-1:0] channel_pulse_control,
  input wire logic [NUM_OUT-1:0] out_pulse_mask,
  input wire logic [15:0] channel_master_divider,
  input wire logic [15:0] out_frame_div,
  input wire fspa_pkg::fspa_width_t pulse_width_sel,
  // Status, core domain.
  output logic [7:0] align_count,
  output logic aligned,
  output logic cfg_busy
);
  import fspa_pkg::*;

  localparam int CFGW = 1 + 1 + 1 + SELW + NUM_OUT + 16 + 16 + 2;

  // Output pulse width in output clock periods.
  function automatic logic [15:0] fspa_width(input fspa_width_t w, input logic [15:0] per);
    logic [15:0] half;
    half = (per > 16'h0001) ? (per >> 1) : 16'h0001;
    unique case (w)
      FSPA_W_ONE: fspa_width = `FSPA_WIDTH_ONE;
      FSPA_W_TWO: fspa_width = `FSPA_WIDTH_TWO;
      FSPA_W_FOUR: fspa_width = `FSPA_WIDTH_FOUR;
      FSPA_W_HALF: fspa_width = half;
    endcase
  endfunction : fspa_width

  // Split a preload into whole periods and a remainder; four steps suffice since no preload exceeds four.
  function automatic logic [31:0] fspa_split(input logic [15:0] val, input logic [15:0] per);
    logic [15:0] rem;
    logic [15:0] quo;
    rem = val;
    quo = 16'h0000;
    for (int j = 0; j < 4; j++) begin
      if (rem >= per) begin
        rem = rem - per;
        quo = quo + 16'h0001;
      end
    end
    fspa_split = {quo, rem};
  endfunction : fspa_split

  // ---------------- Core domain: configuration launch ----------------
  logic [CFGW-1:0] cfg_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic seen_q;
  wire [CFGW-1:0] cfg_vec = {align_mode, edge_fall, frame_align_enable, channel_pulse_control,
                             out_pulse_mask, channel_master_divider, out_frame_div, pulse_width_sel};
  wire cfg_idle = (req_q == ack_s2_q);
  wire cfg_load = cfg_idle && (cfg_vec != cfg_q);

  // The whole word moves under one request so the link never sees a half-updated setup.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= seen_q;
      ack_s2_q <= ack_s1_q;
      if (cfg_load) begin
        cfg_q <= cfg_vec; // [R4] [R14]
        req_q <= ~req_q;
      end
    end
  end

  assign cfg_busy = ~cfg_idle;

  // ---------------- Link domain: reset and configuration capture ----------------
  logic lrst1_q;
  logic lrst2_q;
  wire link_rst_n = lrst2_q;

  // Reset asserts at once and releases on the link clock.
  always_ff @(posedge associated_input_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst1_q <= 1'b0;
      lrst2_q <= 1'b0;
    end else begin
      lrst1_q <= 1'b1;
      lrst2_q <= lrst1_q;
    end
  end

  logic req_s1_q;
  logic req_s2_q;
  logic [CFGW-1:0] lcfg_q;
  wire lk_take = (req_s2_q != seen_q);

  // The core word is held still until this side acknowledges, so sampling it is safe.
  always_ff @(posedge associated_input_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      seen_q <= 1'b0;
      lcfg_q <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      if (lk_take) begin
        lcfg_q <= cfg_q;
        seen_q <= req_s2_q;
      end
    end
  end

  // Field decode of the captured setup.
  wire fspa_mode_t lk_mode = fspa_mode_t'(lcfg_q[CFGW-1]);
  wire lk_fall = lcfg_q[CFGW-2];
  wire lk_en = lcfg_q[CFGW-3];
  wire [SELW-1:0] lk_sel = lcfg_q[CFGW-4 -: SELW];
  wire [NUM_OUT-1:0] lk_mask = lcfg_q[34 +: NUM_OUT];
  wire [15:0] lk_div = lcfg_q[18 +: 16];
  wire [15:0] lk_frm = lcfg_q[2 +: 16];
  wire fspa_width_t lk_wsel = fspa_width_t'(lcfg_q[1:0]);

  // ---------------- Link domain: pulse edge detection ----------------
  logic [NUM_IN-1:0] stb_vec;

  // Every input gets its own detector, so any of them may serve as the pulse input.
  for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_in
    fspa_edge_det u_det (
      .clk(associated_input_clock),
      .rst_n(link_rst_n),
      .pin(pulse_input[gi]),
      .edge_fall(lk_fall),
      .stb(stb_vec[gi])
    ); // [R20] [R5] [R15]
  end

  wire sel_ok = (32'(lk_sel) < NUM_IN);
  wire sel_stb = sel_ok ? stb_vec[lk_sel] : 1'b0; // [R4] [R14]
  wire reload = sel_stb && lk_en; // [R11]

  // ---------------- Link domain: output clock and pulse generation ----------------
  logic [15:0] div_cnt_q;
  logic [15:0] frm_cnt_q;
  logic clk_q;
  logic pls_q;
  logic [NUM_OUT-1:0] outs_q;
  logic ev_tgl_q;

  wire [15:0] div_eff = (lk_div == 16'h0000) ? 16'h0001 : lk_div;
  wire [15:0] frm_eff = (lk_frm == 16'h0000) ? 16'h0001 : lk_frm;
  // Frame mode counts from the clock edge after the pulse, sync mode from the pulse edge itself.
  wire [15:0] pre_raw = (lk_mode == FSPA_MODE_SYNC) ? `FSPA_PRELOAD_SYNC : `FSPA_PRELOAD_FRAME; // [R1] [R13]
  // A preload of a whole output period or more rolls into the frame count, so short dividers keep the phase.
  wire [31:0] pre_div = fspa_split(pre_raw, div_eff);
  wire [31:0] pre_frm = fspa_split(pre_div[31:16], frm_eff);
  wire [15:0] preload = pre_div[15:0];
  wire [15:0] frm_pre = pre_frm[15:0];
  wire div_last = (div_cnt_q >= div_eff - 16'h0001);
  wire frm_last = (frm_cnt_q >= frm_eff - 16'h0001);
  wire [15:0] div_d = reload ? preload : (div_last ? `FSPA_CNT_RST : div_cnt_q + 16'h0001); // [R9] [R18]
  wire [15:0] frm_d = reload ? frm_pre : (div_last ? (frm_last ? `FSPA_CNT_RST : frm_cnt_q + 16'h0001) : frm_cnt_q);
  // Pulse period is a whole number of output clocks, so both stay integer related.
  wire clk_lvl = (div_cnt_q < (div_eff >> 1)); // [R8]
  wire [15:0] pw = fspa_width(lk_wsel, frm_eff);
  wire pls_lvl = (frm_cnt_q < pw); // [R10]

  // Counters restart on an enabled alignment strobe, otherwise run free.
  always_ff @(posedge associated_input_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      div_cnt_q <= `FSPA_CNT_RST;
      frm_cnt_q <= `FSPA_CNT_RST;
      clk_q <= 1'b0;
      pls_q <= 1'b0;
      ev_tgl_q <= 1'b0;
    end else begin
      div_cnt_q <= div_d;
      frm_cnt_q <= frm_d;
      clk_q <= clk_lvl;
      pls_q <= pls_lvl;
      if (reload) begin
        ev_tgl_q <= ~ev_tgl_q;
      end
    end
  end

  // Each output pin carries either the clock or the pulse, as the mask says.
  for (genvar go = 0; go < NUM_OUT; go++) begin : g_out
    always_ff @(posedge associated_input_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
        outs_q[go] <= 1'b0;
      end else begin
        outs_q[go] <= lk_mask[go] ? pls_lvl : clk_lvl; // [R4] [R14]
      end
    end
  end

  assign aligned_output_clock = outs_q;
  assign pulse_output = pls_q;

  // ---------------- Core domain: alignment status ----------------
  logic ev_s1_q;
  logic ev_s2_q;
  logic ev_s3_q;
  logic [7:0] cnt_q;
  logic aligned_q;
  wire ev_pulse = ev_s2_q ^ ev_s3_q;
  // A new alignment wins over the clear from a dropped enable.
  wire aligned_d = ev_pulse ? 1'b1 : (frame_align_enable ? aligned_q : 1'b0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
      cnt_q <= `FSPA_ALIGN_CNT_RST;
      aligned_q <= 1'b0;
    end else begin
      ev_s1_q <= ev_tgl_q;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      cnt_q <= ev_pulse ? cnt_q + 8'h01 : cnt_q;
      aligned_q <= aligned_d; // [R11]
    end
  end

  assign align_count = cnt_q;
  assign aligned = aligned_q;

  // ---------------- Checks ----------------
  a_reload_frame: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R1]
    reload && lk_mode == FSPA_MODE_FRAME && div_eff > 16'h0003 |=> div_cnt_q == 16'h0003 && frm_cnt_q == 16'h0000)
    else $error("frame alignment preload wrong");
  a_reload_sync: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R13]
    reload && lk_mode == FSPA_MODE_SYNC && div_eff > 16'h0004 |=> div_cnt_q == 16'h0004 && frm_cnt_q == 16'h0000)
    else $error("sync alignment preload wrong");
  a_no_align_off: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R11]
    !lk_en |-> !reload ##1 $stable(ev_tgl_q)) else $error("alignment while disabled");
  a_div_wrap: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R8]
    div_last && !reload |=> div_cnt_q == 16'h0000) else $error("divider failed to wrap");
  a_pulse_width: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R10]
    pls_q |-> $past(frm_cnt_q) < $past(pw)) else $error("pulse longer than selected width");
  a_out_route: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R4]
    ##1 outs_q[0] == ($past(lk_mask[0]) ? pls_q : clk_q)) else $error("output routing wrong");
  a_edge_to_load: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R9]
    sel_stb && lk_en && $stable(lcfg_q) |=> ev_tgl_q != $past(ev_tgl_q)) else $error("strobe did not realign");
  a_count_step: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
    ev_pulse |=> cnt_q == $past(cnt_q) + 8'h01 && aligned_q) else $error("alignment not counted");
  a_reload_roll: assert property (@(posedge associated_input_clock) disable iff (!link_rst_n) // [R18]
    reload && lk_mode == FSPA_MODE_SYNC && div_eff == 16'h0004 && frm_eff > 16'h0001
    |=> div_cnt_q == 16'h0000 && frm_cnt_q == 16'h0001) else $error("sync preload did not roll over");
  a_align_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
    !frame_align_enable && !ev_pulse |=> !aligned_q) else $error("aligned kept while disabled");
  a_cfg_stable: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
    cfg_busy |=> $stable(cfg_q)) else $error("setup word moved during hand-over");

  c_frame_align: cover property (@(posedge associated_input_clock) disable iff (!link_rst_n)
    reload && lk_mode == FSPA_MODE_FRAME);
  c_sync_align: cover property (@(posedge associated_input_clock) disable iff (!link_rst_n)
    reload && lk_mode == FSPA_MODE_SYNC);
  c_fall_align: cover property (@(posedge associated_input_clock) disable iff (!link_rst_n)
    reload && lk_fall);
  c_pulse_out: cover property (@(posedge associated_input_clock) disable iff (!link_rst_n)
    $rose(pls_q));
  c_roll_align: cover property (@(posedge associated_input_clock) disable iff (!link_rst_n)
    reload && preload != pre_raw);

endmodule : fspa_top

//--- fspa_consts.svh
`ifndef FSPA_CONSTS_SVH
`define FSPA_CONSTS_SVH

// Core clock period, and the shortest pulse that the source should hold.
`define FSPA_CORE_PERIOD_NS 100
`define FSPA_MIN_PULSE_NS 10
`define FSPA_MIN_PULSE_CYC ((`FSPA_MIN_PULSE_NS + `FSPA_CORE_PERIOD_NS - 1) / `FSPA_CORE_PERIOD_NS)

// Link clock cycles between the selected pulse edge and the counter reload.
`define FSPA_PRELOAD_FRAME 16'h0003
`define FSPA_PRELOAD_SYNC 16'h0004

// Counter and status reset values.
`define FSPA_CNT_RST 16'h0000
`define FSPA_ALIGN_CNT_RST 8'h00

// Output pulse widths in output clock periods.
`define FSPA_WIDTH_ONE 16'h0001
`define FSPA_WIDTH_TWO 16'h0002
`define FSPA_WIDTH_FOUR 16'h0004

`endif

//--- fspa_pkg.sv
package fspa_pkg;

  // Alignment reference: frame pulse marks the next clock edge, sync pulse is the edge.
  typedef enum logic {
    FSPA_MODE_FRAME = 1'b0,
    FSPA_MODE_SYNC = 1'b1
  } fspa_mode_t;

  // Width of the generated output pulse.
  typedef enum logic [1:0] {
    FSPA_W_ONE = 2'b00,
    FSPA_W_TWO = 2'b01,
    FSPA_W_FOUR = 2'b10,
    FSPA_W_HALF = 2'b11
  } fspa_width_t;

endpackage : fspa_pkg

//--- fspa_edge_det.sv
`timescale 1ns/1ns
module fspa_edge_det (
  // Link clock and link reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw pulse pin and edge polarity.
  input wire logic pin,
  input wire logic edge_fall,
  // One-cycle strobe on the chosen edge.
  output logic stb
);
  import fspa_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic stb_q;
  wire hit = edge_fall ? (~s2_q & s3_q) : (s2_q & ~s3_q); // [R2] [R12] [R19]

  // Two flops tame the pin; the third only feeds the edge compare.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      stb_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stb_q <= hit; // [R20]
    end
  end

  assign stb = stb_q;

  a_edge_rise: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    stb_q && !$past(edge_fall) |-> $past(s2_q) && !$past(s3_q)) else $error("rise strobe without rise");
  a_edge_fall: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
    stb_q && $past(edge_fall) |-> !$past(s2_q) && $past(s3_q)) else $error("fall strobe without fall");
  a_strobe_single: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
    stb_q && $stable(edge_fall) |=> !stb_q) else $error("strobe longer than one cycle");

endmodule : fspa_edge_det

//--- fspa_src_model.sv
`timescale 1ns/1ns
// Reference clock and pulse source standing at the link pins.
module fspa_src_model (
  // Link clock and raw pulse pins.
  output logic clk,
  output logic [3:0] pin
);
  // The reference clock runs free at 30 ns, offset from the core clock.
  initial begin
    clk = 1'b0;
    pin = 4'h0;
    #7;
    forever #15 clk = ~clk;
  end
  // One positive pulse of three link periods, well above 10 ns.
  // One pulse per call keeps the rate an integer fraction of the clock.
  task automatic fire(input int i);
    @(posedge clk);
    #1;
    pin[i] = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    pin[i] = 1'b0;
  endtask : fire
endmodule : fspa_src_model

//--- tb_frame_sync_pulse_alignment.sv
`timescale 1ns/1ns
module tb_frame_sync_pulse_alignment;
  import fspa_pkg::*;
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
  logic core_clk, rst_n, lclk, pout, fen, efall, busy, algn;
  logic [1:0] sel;
  fspa_mode_t mode;
  fspa_width_t wsel;
  logic [3:0] pin;
  logic [7:0] aout, msk, acnt;
  logic [15:0] div, fdiv;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int k1, k;
  // Device under test and the source model at its link pins.
  fspa_top fspa_top_inst (.core_clk(core_clk), .rst_n(rst_n), .associated_input_clock(lclk),
    .pulse_input(pin), .aligned_output_clock(aout), .pulse_output(pout), .align_mode(mode),
    .edge_fall(efall), .frame_align_enable(fen), .channel_pulse_control(sel), .out_pulse_mask(msk),
    .channel_master_divider(div), .out_frame_div(fdiv), .pulse_width_sel(wsel), .align_count(acnt),
    .aligned(algn), .cfg_busy(busy));
  fspa_src_model fspa_src_model_inst (.clk(lclk), .pin(pin));
  // Core clock, 100 ns.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Hang guard; the whole run needs well under a thousand core cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // Configuration crosses to the link slowly, so wait for the hand-over to end.
  task automatic cfg(input fspa_mode_t m, input logic f, input logic en, input logic [1:0] s,
                     input fspa_width_t w = FSPA_W_ONE);
    @(posedge core_clk);
    #1;
    mode = m;
    efall = f;
    fen = en;
    sel = s;
    wsel = w;
    repeat (3) @(posedge core_clk);
    #1;
    for (int i = 0; i < 50 && busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask : cfg
  // One pulse on pin i, then the event counter must have moved by inc.
  task automatic pulse_cnt(input int i, input int inc);
    logic [7:0] old;
    old = acnt;
    fspa_src_model_inst.fire(i);
    repeat (20) @(posedge core_clk);
    `CHK("align_count", old + 8'(inc), acnt)
  endtask : pulse_cnt
  // Link cycles to the next pulse_output rise, sampled on falling link edges.
  task automatic to_rise(output int n);
    logic p;
    @(negedge lclk);
    n = 0;
    do begin
      p = pout;
      @(negedge lclk);
      n++;
    end while (n < 100 && !(p === 1'b0 && pout === 1'b1));
  endtask : to_rise
  // Pulse after a gap, settle, then measure the output phase.
  task automatic phase(input int gap, output int n);
    repeat (gap) @(posedge lclk);
    fspa_src_model_inst.fire(sel);
    repeat (50) @(posedge lclk);
    to_rise(n);
  endtask : phase
  // Every pin can be chosen; the next pin over and a pulse with alignment disabled are ignored.
  task automatic t_count;
    for (int i = 0; i < 4; i++) begin
      cfg(FSPA_MODE_FRAME, 1'b0, 1'b1, 2'(i));
      pulse_cnt(i, 1);
      pulse_cnt((i + 1) % 4, 0);
    end
    `CHK("aligned", 1'b1, algn)
    cfg(FSPA_MODE_FRAME, 1'b0, 1'b0, 2'd0);
    pulse_cnt(0, 0);
    `CHK("aligned", 1'b0, algn)
    $display("test count done");
  endtask : t_count
  // Output phase follows the pulse, in both modes and both edges.
  task automatic t_phase;
    cfg(FSPA_MODE_FRAME, 1'b0, 1'b1, 2'd2);
    phase(13, k1);
    phase(7, k);
    `CHK("frame phase", k1, k)
    cfg(FSPA_MODE_FRAME, 1'b1, 1'b1, 2'd2);
    phase(11, k);
    `CHK("frame fall phase", ((k1 + 2) % 40) + 1, k)
    cfg(FSPA_MODE_SYNC, 1'b0, 1'b1, 2'd2);
    phase(5, k);
    `CHK("sync phase", ((k1 + 38) % 40) + 1, k)
    cfg(FSPA_MODE_SYNC, 1'b1, 1'b1, 2'd2);
    phase(9, k);
    `CHK("sync fall phase", ((k1 + 1) % 40) + 1, k)
    $display("test phase done");
  endtask : t_phase
  // Pulse width per setting, frame period, and the pin mapping of outputs.
  task automatic t_width;
    int wid[4] = '{4, 8, 16, 20};
    int hi, per, clk_hi, mir;
    for (int i = 0; i < 4; i++) begin
      cfg(FSPA_MODE_FRAME, 1'b0, 1'b1, 2'd0, fspa_width_t'(i));
      to_rise(hi);
      hi = 0;
      per = 0;
      clk_hi = 0;
      mir = 0;
      while (per < 40) begin
        hi += (pout === 1'b1);
        clk_hi += (aout[1] === 1'b1);
        mir += (aout[0] !== pout);
        @(negedge lclk);
        per++;
      end
      `CHK("pulse width", wid[i], hi)
      to_rise(per);
      `CHK("frame period", int'(fdiv) * int'(div) - 1, per)
      `CHK("clock high", 20, clk_hi)
      `CHK("pulse pin map", 0, mir)
    end
    $display("test width done");
  endtask : t_width
  // Reset, then the scenarios in turn.
  initial begin
    rst_n = 1'b0;
    mode = FSPA_MODE_FRAME;
    efall = 1'b0;
    fen = 1'b0;
    sel = 2'd0;
    msk = 8'h01;
    div = 16'h0004;
    fdiv = 16'h000a;
    wsel = FSPA_W_ONE;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    cfg(FSPA_MODE_FRAME, 1'b0, 1'b0, 2'd0);
    `CHK("align_count", 8'h00, acnt)
    `CHK("aligned", 1'b0, algn)
    t_count();
    t_phase();
    t_width();
    end_of_test();
  end
endmodule : tb_frame_sync_pulse_alignment
